// ### hw/phd_port_ctrl.sv
// top: handshake/dma control register and one-line output handshake for the parallel port
//
// Overview of operation
// - mode 010, dma on, compare selects output dma
// - one-line output mode drives valid strobe low
// - port latch write raises valid strobe unless handshake is off (mode bits 6:5 = 11)
// - each compare-triggered transfer writes new port data
// - strobe low while latches change, high after only in one-line output mode 010
// - control register resets to all ones
// - mode bits decode to five handshake modes
// - dma disable bit is active low enable
// - direction bit: one input, zero output
// - trigger enable lets timer event start dma
// - select picks compare when one, capture zero
// - control bit zero always reads one
`timescale 1ns/100ps
module phd_port_ctrl (
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // timer events from the multifunction timer
    input  wire logic        timer_compare_event_in,
    input  wire logic        timer_capture_event_in,
    // port pins and handshake
    input  wire logic [7:0]  port_pins_in,
    output logic      [7:0]  port_data_out,
    output logic             output_data_valid_out,
    output logic             dma_request_out
);
    import phd_pkg::*;

    function automatic logic rising(input logic now_v, input logic old_v);
        rising = now_v & ~old_v;
    endfunction : rising

    // control and data state
    logic [7:0]            control_r;
    logic [7:0]            port_latch_r;
    logic                  valid_r;
    logic                  dma_req_r;
    logic [7:0]            transfer_cnt_r;
    logic [PHD_BUF_AW-1:0] wr_ptr_r;
    logic [PHD_BUF_AW-1:0] rd_ptr_r;
    logic [3:0]            settle_cnt_r;
    logic                  ack_r;
    phd_state_t            state_r;
    logic [7:0]            buf_rd_data;

    // timer events may come from another domain: three-stage sync
    logic [2:0] cmp_sync_r;
    logic [2:0] cap_sync_r;
    logic       cmp_level_r;
    logic       cap_level_r;
    logic [7:0] pins_s1_r;
    logic [7:0] pins_s2_r;
    logic [7:0] pins_s3_r;
    logic [7:0] pins_agreed_r;

    // a pin bit moves only when stages two and three agree, so a slow edge counts once
    function automatic logic [7:0] agreed(input logic [7:0] s2_v, input logic [7:0] s3_v, input logic [7:0] old_v);
        agreed = (s3_v & ~(s2_v ^ s3_v)) | (old_v & (s2_v ^ s3_v));
    endfunction : agreed

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            cmp_sync_r  <= 3'h0;
            cap_sync_r  <= 3'h0;
            cmp_level_r <= 1'b0;
            cap_level_r <= 1'b0;
        end else begin
            cmp_sync_r <= {cmp_sync_r[1:0], timer_compare_event_in};
            cap_sync_r <= {cap_sync_r[1:0], timer_capture_event_in};
            if (cmp_sync_r[1] == cmp_sync_r[2]) begin
                cmp_level_r <= cmp_sync_r[2];
            end
            if (cap_sync_r[1] == cap_sync_r[2]) begin
                cap_level_r <= cap_sync_r[2];
            end
        end
    end

    // pin samples take their own three stages
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pins_s1_r     <= 8'h00;
            pins_s2_r     <= 8'h00;
            pins_s3_r     <= 8'h00;
            pins_agreed_r <= 8'h00;
        end else begin
            pins_s1_r     <= port_pins_in;
            pins_s2_r     <= pins_s1_r;
            pins_s3_r     <= pins_s2_r;
            pins_agreed_r <= agreed(pins_s2_r, pins_s3_r, pins_agreed_r);
        end
    end

    // edge of the agreed level, compared with the previous agreed level
    wire cmp_edge = rising(cmp_sync_r[2], cmp_level_r) & (cmp_sync_r[1] == cmp_sync_r[2]);
    wire cap_edge = rising(cap_sync_r[2], cap_level_r) & (cap_sync_r[1] == cap_sync_r[2]);

    // control field decode
    wire phd_mode_t mode      = phd_mode_t'(control_r[PHD_MODE_HI:PHD_MODE_LO]);
    wire hs_disabled          = (control_r[6:5] == 2'b11);
    wire hs_out1              = (mode == PHD_HS_OUT1);
    wire hs_out2              = (mode == PHD_HS_OUT2);
    wire hs_in                = (control_r[6:5] == 2'b01);
    wire hs_bidir             = (control_r[6:5] == 2'b00);
    wire dma_enabled          = ~control_r[PHD_DMA_DIS_BIT];
    wire dir_output           = ~control_r[PHD_DIR_BIT];
    wire trig_enabled         = control_r[PHD_TRIG_EN_BIT];
    wire trig_sel_compare     = control_r[PHD_TRIG_SEL_BIT];
    wire trig_event           = trig_sel_compare ? cmp_edge : cap_edge;
    wire dma_path_on          = ~hs_disabled & dma_enabled & trig_enabled;
    wire output_dma_on        = dma_path_on & dir_output;
    // one-line output with compare trigger; settle_last restores the strobe in mode 010 with either trigger
    wire out1_cmp_on          = output_dma_on & hs_out1 & trig_sel_compare;
    wire buf_has_data         = (transfer_cnt_r != 8'h00);

    // address match, shared by the write strobes and the read select
    function automatic logic addr_hit(input logic [7:0] addr_v, input logic [7:0] reg_v);
        addr_hit = (addr_v == reg_v);
    endfunction : addr_hit

    // avalon decode; every access answers after one wait cycle
    wire sel_ctl   = addr_hit(avs_address_in, PHD_ADDR_CONTROL);
    wire sel_port  = addr_hit(avs_address_in, PHD_ADDR_PORT);
    wire sel_stat  = addr_hit(avs_address_in, PHD_ADDR_STATUS);
    wire sel_pins  = addr_hit(avs_address_in, PHD_ADDR_TIMEREV);
    wire sel_data  = addr_hit(avs_address_in, PHD_ADDR_DATA0);
    wire req       = (avs_read_in | avs_write_in) & ~ack_r;
    // writes land in the answer cycle, at the edge where the master sees waitrequest low
    wire take_wr   = ack_r & avs_write_in;
    wire wr_ctl    = take_wr & sel_ctl;
    wire wr_port   = take_wr & sel_port;
    wire wr_data   = take_wr & sel_data;
    logic [31:0] rd_mux;
    // status packs mode flags, strobe and sequencer phase
    wire [7:0]  status_byte = {hs_out2, hs_out1, dma_req_r, valid_r, state_r, hs_bidir, hs_in};

    always_comb begin
        if (sel_ctl) begin
            rd_mux = {24'h0, control_r[7:1], 1'b1};
        end else if (sel_port) begin
            rd_mux = {24'h0, port_latch_r};
        end else if (sel_stat) begin
            rd_mux = {24'h0, status_byte};
        end else if (sel_pins) begin
            rd_mux = {24'h0, pins_agreed_r};
        end else if (sel_data) begin
            rd_mux = {24'h0, transfer_cnt_r};
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    // ack lasts one cycle, so a request still held is answered again every second cycle
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // dma source buffer
    logic buf_push;
    logic buf_pop;
    // a full buffer drops the word; software reads the count before pushing
    assign buf_push = wr_data & (transfer_cnt_r != 8'(PHD_BUF_DEPTH));
    phd_buf_mem u_buf (
        .mclk_in     (mclk_in),
        .wr_en_in    (buf_push),
        .wr_addr_in  (wr_ptr_r),
        .wr_data_in  (avs_writedata_in[7:0]),
        .rd_addr_in  (rd_ptr_r),
        .rd_data_out (buf_rd_data)
    );

    // transfer sequencer
    phd_state_t state_nxt;
    logic       start_xfer;
    assign start_xfer = (state_r == PHD_ST_IDLE) & trig_event & output_dma_on & buf_has_data;
    assign buf_pop    = start_xfer;
    // sequencer phases; the read pointer moves only once its word sits in the latch
    wire in_fetch    = (state_r == PHD_ST_FETCH);
    wire settle_last = (state_r == PHD_ST_SETTLE) & (settle_cnt_r == 4'h1);
    wire port_load   = (state_r == PHD_ST_SETTLE) & (settle_cnt_r == PHD_SETTLE_CYC);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PHD_ST_IDLE: begin
                if (start_xfer) begin
                    state_nxt = PHD_ST_FETCH;
                end
            end
            PHD_ST_FETCH: begin
                state_nxt = PHD_ST_SETTLE;
            end
            PHD_ST_SETTLE: begin
                if (settle_cnt_r == 4'h1) begin
                    state_nxt = PHD_ST_IDLE;
                end
            end
            default: begin
                state_nxt = PHD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            control_r      <= PHD_CONTROL_RESET;
            state_r        <= PHD_ST_IDLE;
            settle_cnt_r   <= 4'h0;
            wr_ptr_r       <= '0;
            rd_ptr_r       <= '0;
            transfer_cnt_r <= 8'h00;
            dma_req_r      <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (wr_ctl) begin
                control_r <= {avs_writedata_in[7:1], 1'b1};
            end
            if (buf_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (port_load) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            transfer_cnt_r <= transfer_cnt_r + 8'(buf_push) - 8'(buf_pop);
            dma_req_r      <= start_xfer;
            if (in_fetch) begin
                settle_cnt_r <= PHD_SETTLE_CYC;
            end else if (settle_cnt_r != 4'h0) begin
                settle_cnt_r <= settle_cnt_r - 4'h1;
            end
        end
    end

    // port latches and valid strobe
    // transfer steps outrank bus writes: a port write during a transfer is lost
    logic       valid_nxt;
    logic [7:0] port_nxt;
    always_comb begin
        port_nxt  = port_latch_r;
        valid_nxt = valid_r;
        if (port_load) begin
            port_nxt  = buf_rd_data;
            valid_nxt = 1'b0;
        end else if (in_fetch) begin
            valid_nxt = 1'b0;
        end else if (settle_last) begin
            valid_nxt = out1_cmp_on | hs_out1;
        end else if (wr_port) begin
            port_nxt  = avs_writedata_in[7:0];
            valid_nxt = ~hs_disabled;
        end else if (wr_ctl && (avs_writedata_in[7:5] == PHD_HS_OUT1 || avs_writedata_in[6:5] == 2'b11)) begin
            valid_nxt = 1'b0;
        end else if (hs_disabled) begin
            valid_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            port_latch_r <= PHD_PORT_RESET;
            valid_r      <= 1'b0;
        end else begin
            port_latch_r <= port_nxt;
            valid_r      <= valid_nxt;
        end
    end

    // registered outputs; waitrequest is low only in the answer cycle
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            avs_waitrequest_out   <= 1'b1;
            avs_readdata_out      <= 32'h0000_0000;
            port_data_out         <= PHD_PORT_RESET;
            output_data_valid_out <= 1'b0;
            dma_request_out       <= 1'b0;
        end else begin
            avs_waitrequest_out   <= ~req;
            avs_readdata_out      <= rd_mux;
            port_data_out         <= port_nxt;
            output_data_valid_out <= valid_nxt;
            dma_request_out       <= start_xfer;
        end
    end
endmodule : phd_port_ctrl

// ### hw/phd_pkg.sv
// package: constants for the port handshake and dma control block
package phd_pkg;
    // register map, byte addresses on the avalon bus
    localparam logic [7:0] PHD_ADDR_CONTROL = 8'hF7;
    localparam logic [7:0] PHD_ADDR_PORT    = 8'hE5;
    localparam logic [7:0] PHD_ADDR_STATUS  = 8'hE6;
    localparam logic [7:0] PHD_ADDR_TIMEREV = 8'hE7;
    localparam logic [7:0] PHD_ADDR_DATA0   = 8'hE8;
    // control register fields
    localparam int PHD_MODE_HI       = 7;
    localparam int PHD_MODE_LO       = 5;
    localparam int PHD_DMA_DIS_BIT   = 4;
    localparam int PHD_DIR_BIT       = 3;
    localparam int PHD_TRIG_EN_BIT   = 2;
    localparam int PHD_TRIG_SEL_BIT  = 1;
    localparam int PHD_FIXED_BIT     = 0;
    localparam logic [7:0] PHD_CONTROL_RESET = 8'hFF;
    localparam logic [7:0] PHD_PORT_RESET    = 8'h00;
    // dma source buffer depth
    localparam int PHD_BUF_AW    = 4;
    localparam int PHD_BUF_DEPTH = 16;
    // strobe low time while port latches change
    localparam int PHD_SETTLE_NS     = 20;
    localparam int PHD_CLK_PERIOD_NS = 10;
    localparam logic [3:0] PHD_SETTLE_CYC =
        4'((PHD_SETTLE_NS + PHD_CLK_PERIOD_NS - 1) / PHD_CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        PHD_HS_BIDIR    = 3'b000,
        PHD_HS_IN1      = 3'b001,
        PHD_HS_OUT1     = 3'b010,
        PHD_HS_OFF      = 3'b011,
        PHD_HS_BIDIR_B  = 3'b100,
        PHD_HS_IN2      = 3'b101,
        PHD_HS_OUT2     = 3'b110,
        PHD_HS_OFF_B    = 3'b111
    } phd_mode_t;

    typedef enum logic [1:0] {
        PHD_ST_IDLE   = 2'b00,
        PHD_ST_FETCH  = 2'b01,
        PHD_ST_SETTLE = 2'b10
    } phd_state_t;
endpackage : phd_pkg

// ### hw/phd_buf_mem.sv
// small memory holding words that dma transfers move to the port
`timescale 1ns/100ps
module phd_buf_mem (
    // clock
    input  wire logic                          mclk_in,
    // write side
    input  wire logic                          wr_en_in,
    input  wire logic [phd_pkg::PHD_BUF_AW-1:0] wr_addr_in,
    input  wire logic [7:0]                    wr_data_in,
    // registered read side
    input  wire logic [phd_pkg::PHD_BUF_AW-1:0] rd_addr_in,
    output logic      [7:0]                    rd_data_out
);
    import phd_pkg::*;
    logic [7:0] mem_r [PHD_BUF_DEPTH];

    always_ff @(posedge mclk_in) begin
        if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_r[rd_addr_in];
    end
endmodule : phd_buf_mem

// ### bench/phd_port_ctrl_chk.sv
// checker: bus answer, strobe and dma trigger properties
`timescale 1ns/100ps
module phd_port_ctrl_chk import phd_pkg::*; (
    // clock, reset and bus
    input wire logic        mclk_in,
    input wire logic        reset_in,
    input wire logic [7:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    // port side
    input wire logic [7:0]  port_data_out,
    input wire logic        output_data_valid_out,
    input wire logic        dma_request_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    logic [7:0] ctl_r;
    wire logic  acc     = !avs_waitrequest_out;
    wire logic  wr_ctl  = acc && avs_write_in && avs_address_in == PHD_ADDR_CONTROL;
    wire logic  wr_port = acc && avs_write_in && avs_address_in == PHD_ADDR_PORT;
    // shadow loads on the same edge as the real register, and the bench keeps events clear of writes
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            ctl_r <= PHD_CONTROL_RESET;
        end else if (wr_ctl) begin
            ctl_r <= avs_writedata_in[7:0];
        end
    end
    bus_answer_a: assert property ((avs_read_in || avs_write_in) && !acc |=> acc)
        else $error("bus answer late");
    fixed_bit_a: assert property (acc && avs_read_in && avs_address_in == PHD_ADDR_CONTROL |-> avs_readdata_out[0])
        else $error("bit zero low");
    reset_state_a: assert property ($fell(reset_in) |-> port_data_out == PHD_PORT_RESET && !output_data_valid_out)
        else $error("reset state wrong");
    out1_low_a: assert property (wr_ctl && avs_writedata_in[7:5] == 3'h2 |=> !output_data_valid_out)
        else $error("strobe not low");
    port_valid_a: assert property (wr_port && ctl_r[6:5] != 2'h3 |=> output_data_valid_out)
        else $error("strobe not raised");
    port_quiet_a: assert property (wr_port && ctl_r[6:5] == 2'h3 |=> !output_data_valid_out)
        else $error("strobe active when off");
    dma_low_a: assert property (dma_request_out |-> ##[0:2] !output_data_valid_out)
        else $error("strobe not dropped");
    dma_data_a: assert property (dma_request_out |-> ##[1:4] $changed(port_data_out))
        else $error("port data unchanged");
    valid_back_a: assert property (dma_request_out && ctl_r[7:5] == 3'h2 |-> ##[2:8] $rose(output_data_valid_out))
        else $error("strobe not restored");
    data_hold_a: assert property ($changed(port_data_out) && !$past(avs_write_in) |-> !output_data_valid_out)
        else $error("data moved under strobe");
    dma_off_a: assert property (ctl_r[4] |-> !dma_request_out)
        else $error("dma while disabled");
    dir_in_a: assert property (ctl_r[3] |-> !dma_request_out)
        else $error("output dma in input mode");
    trig_off_a: assert property (!ctl_r[2] || ctl_r[6:5] == 2'h3 |-> !dma_request_out)
        else $error("dma without trigger");
    cover property (dma_request_out);
    cover property (wr_port);
    cover property ($rose(output_data_valid_out));
endmodule : phd_port_ctrl_chk

// ### bench/phd_periph_model.sv
// partner: peripheral latching port data on the strobe rise
`timescale 1ns/100ps
module phd_periph_model (
    // port side
    input wire logic       mclk_in,
    input wire logic [7:0] port_data_in,
    input wire logic       valid_in
);
    logic       valid_r;
    logic [7:0] got_q[$];
    always @(posedge mclk_in) begin
        valid_r <= valid_in;
        if (valid_in && !valid_r) begin
            got_q.push_back(port_data_in);
        end
    end
endmodule : phd_periph_model

// ### bench/phd_port_ctrl_tb.sv
// testbench: register, handshake and timer-triggered dma checks
`timescale 1ns/100ps
module phd_port_ctrl_tb;
    import phd_pkg::*;
    logic        mclk_in = 1'h0;
    logic        reset_in = 1'h1;
    logic [7:0]  avs_address_in = 8'h00;
    logic        avs_read_in = 1'h0;
    logic        avs_write_in = 1'h0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        timer_compare_event_in = 1'h0;
    logic        timer_capture_event_in = 1'h0;
    logic [7:0]  port_pins_in = 8'h00;
    logic [7:0]  port_data_out;
    logic        output_data_valid_out;
    logic        dma_request_out;
    int          failures = 0;
    int          checked = 0;
    logic [7:0]  port_m = PHD_PORT_RESET;
    logic [7:0]  buf_q[$];
    logic [7:0]  cfg[4] = '{8'h67, 8'h57, 8'h4F, 8'h43};
    logic [31:0] q;
    logic [7:0]  w;
    logic [7:0]  lw;
    always #5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) port_pins_in <= 8'($urandom);
    phd_port_ctrl dut_u (.mclk_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .timer_compare_event_in,
        .timer_capture_event_in, .port_pins_in, .port_data_out, .output_data_valid_out, .dma_request_out);
    phd_periph_model periph_u (.mclk_in, .port_data_in(port_data_out), .valid_in(output_data_valid_out));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask : chk
    task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= {24'h0, d};
        avs_write_in <= we;
        avs_read_in <= !we;
        do begin
            @(posedge mclk_in);
            n++;
        end while (avs_waitrequest_out !== 1'h0 && n < 50);
        q = avs_readdata_out;
        avs_write_in <= 1'h0;
        avs_read_in <= 1'h0;
        chk("bus answer", 32'h0, 32'(n >= 50));
        @(posedge mclk_in);
    endtask : bus
    task automatic push();
        lw = lw + 8'h01 + 8'($urandom % 255);
        buf_q.push_back(lw);
        bus(1'h1, PHD_ADDR_DATA0, lw);
    endtask : push
    // event is held three cycles so the synchroniser sees a clean edge
    task automatic fire(input logic cmp, input logic go);
        timer_compare_event_in <= cmp;
        timer_capture_event_in <= !cmp;
        repeat (3) @(posedge mclk_in);
        timer_compare_event_in <= 1'h0;
        timer_capture_event_in <= 1'h0;
        repeat (16) @(posedge mclk_in);
        if (go) begin
            port_m = buf_q.pop_front();
            chk("latched", {24'h0, port_m}, {24'h0, periph_u.got_q[$]});
            chk("valid", 32'h1, {31'h0, output_data_valid_out});
        end
        chk("port data", {24'h0, port_m}, {24'h0, port_data_out});
    endtask : fire
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        void'($urandom(94873));
        repeat (8) @(posedge mclk_in);
        reset_in <= 1'h0;
        @(posedge mclk_in);
        bus(1'h0, PHD_ADDR_CONTROL, 8'h00);
        chk("control reset", 32'hFF, q);
        bus(1'h0, 8'h10, 8'h00);
        chk("unmapped read", 32'h0, q);
        repeat (4) begin
            w = 8'($urandom) | 8'h10;
            bus(1'h1, PHD_ADDR_CONTROL, w);
            bus(1'h0, PHD_ADDR_CONTROL, 8'h00);
            chk("control readback", {24'h0, w | 8'h01}, q);
        end
        $display("test registers done");
        for (int m = 0; m < 8; m++) begin
            bus(1'h1, PHD_ADDR_CONTROL, {m[2:0], 5'h1F});
            if (m == 2 || m[1:0] == 2'h3)
                chk("valid forced low", 32'h0, {31'h0, output_data_valid_out});
            w = 8'($urandom);
            bus(1'h1, PHD_ADDR_PORT, w);
            port_m = w;
            chk("port write", {24'h0, w}, {24'h0, port_data_out});
            chk("valid after write", {31'h0, m[1:0] != 2'h3}, {31'h0, output_data_valid_out});
        end
        $display("test modes done");
        lw = port_m;
        repeat (4) push();
        bus(1'h0, PHD_ADDR_DATA0, 8'h00);
        chk("buffer count", 32'h4, q);
        bus(1'h1, PHD_ADDR_CONTROL, 8'h47);
        repeat (3) fire(1'h1, 1'h1);
        fire(1'h0, 1'h0);
        bus(1'h1, PHD_ADDR_CONTROL, 8'h45);
        fire(1'h1, 1'h0);
        fire(1'h0, 1'h1);
        $display("test dma done");
        push();
        foreach (cfg[i]) begin
            bus(1'h1, PHD_ADDR_CONTROL, cfg[i]);
            fire(1'h1, 1'h0);
        end
        bus(1'h1, PHD_ADDR_CONTROL, 8'h47);
        fire(1'h1, 1'h1);
        $display("test refusal done");
        final_report();
    end
    initial begin
        repeat (5000) @(posedge mclk_in);
        $display("Error watchdog expected done seen hang");
        failures++;
        final_report();
    end
endmodule : phd_port_ctrl_tb
bind phd_port_ctrl phd_port_ctrl_chk chk_u (.mclk_in, .reset_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .port_data_out,
    .output_data_valid_out, .dma_request_out);
